// ### verilog/ars_dev.sv
// Converter housekeeping: serial reset, synchronisation, temperature, outputs, parity
`default_nettype none

module ars_dev
  import ars_pkg::*;
#(
  parameter int OUT_PERIOD = OUT_PERIOD_CYC  // Core cycles per output period
) (
  input  wire logic        CLK_SYS_I,      // Core clock
  input  wire logic        NRST_I,         // Power-up reset, active low
  input  wire logic        CE_I,           // Clock enable
  ars_link_if.dev          LINK,           // Serial link
  input  wire logic [23:0] ANALOG_CODE_I,  // Modulator code for the analog input
  input  wire logic [11:0] TEMP_KELVIN_I,  // Die temperature in kelvin
  input  wire logic [3:0]  GPO_PIN_I,      // Sensed output pin levels
  output logic      [3:0]  GPO_PIN_O,      // Output pin levels
  output logic      [3:0]  GPO_PIN_OE_O,   // Output pin enables
  output logic             TEMP_SEL_O      // Temperature sensor routed to input
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam logic [7:0] SY_RST = 8'h0F;

  logic [7:0]  sy1_q;
  logic [7:0]  sy2_q;
  logic        sclk_s;
  logic        din_s;
  logic        cs_n_s;
  logic        sync_n_s;
  logic [3:0]  pins_s;
  logic        sclk_prev_q;
  logic        sync_prev_q;
  logic        rise;
  logic        soft_q;
  logic        rst_all;
  logic [5:0]  ones_q;
  ars_ser_e    st_q;
  logic [5:0]  bcnt_q;
  logic [5:0]  len_q;
  logic [2:0]  addr_q;
  logic [31:0] sh_q;
  logic [7:0]  comm;
  logic [31:0] rd_word;
  logic [5:0]  rd_len;
  logic        wr_stb;
  logic        rd_data_done;
  logic [7:0]  mode_q;
  logic [7:0]  cfg_q;
  logic [7:0]  gpo_q;
  logic [7:0]  status;
  logic        par;
  logic        rdy_n_q;
  logic [23:0] data_q;
  logic        filt_rst;
  logic        run_q;
  logic [31:0] pcnt_q;
  logic [2:0]  nper_q;
  logic [2:0]  need_per;
  logic        upd;
  logic [23:0] temp_code;
  logic [23:0] sample;
  logic        dout_q;
  logic        oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; pins and link come from other domains
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      sy1_q <= SY_RST;
      sy2_q <= SY_RST;
    end else if (CE_I) begin
      sy1_q <= {GPO_PIN_I, LINK.sync_n, LINK.cs_n, LINK.din, LINK.sclk};
      sy2_q <= sy1_q;
    end
  end

  assign sclk_s   = sy2_q[0];
  assign din_s    = sy2_q[1];
  assign cs_n_s   = sy2_q[2];
  assign sync_n_s = sy2_q[3];
  assign pins_s   = sy2_q[7:4];

  // Edge history for serial clock and synchronisation
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      sclk_prev_q <= 1'b1;
      sync_prev_q <= 1'b1;
    end else if (CE_I) begin
      sclk_prev_q <= sclk_s;
      sync_prev_q <= sync_n_s;
    end
  end

  // Data is sampled on rising serial clock inside a frame
  assign rise = CE_I & sclk_s & ~sclk_prev_q & ~cs_n_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial reset detection
  // Power-up and serial reset share one path; power-up alone also clears the synchronisers and edge history
  assign rst_all = ~NRST_I | soft_q;  // [RULE_02] [RULE_03]

  // Run of ones; any zero restarts the count
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      ones_q <= '0;
    end else if (rise) begin
      ones_q <= din_s ? ones_q + 6'd1 : 6'd0;  // [RULE_21]
    end
  end

  // One-cycle reset pulse on the fortieth one
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      soft_q <= 1'b0;
    end else if (CE_I) begin
      soft_q <= rise & din_s & (ones_q == 6'(RESET_ONES - 1)) & ~soft_q;  // [RULE_01]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame decoder
  assign comm         = {sh_q[6:0], din_s};
  assign wr_stb       = rise & (st_q == S_WR) & (bcnt_q == 6'd7);
  assign rd_data_done = rise & (st_q == S_RD) & (bcnt_q == len_q - 6'd1) & (addr_q == REG_DATA);

  // Status word with parity over the result
  assign par    = mode_q[MD_PAR_EN] & ^data_q;  // [RULE_17] [RULE_19]
  assign status = {rdy_n_q, 2'b00, par, 4'h0};

  // Word presented for a read, left aligned
  always_comb begin
    rd_word = '0;
    rd_len  = 6'd8;
    case (comm[2:0])
      REG_STATUS: rd_word = {status, 24'h00_0000};
      REG_MODE:   rd_word = {mode_q, 24'h00_0000};
      REG_CONFIG: rd_word = {cfg_q, 24'h00_0000};
      REG_DATA: begin
        rd_word = {data_q, mode_q[MD_APPEND] ? status : 8'h00};  // [RULE_18]
        rd_len  = mode_q[MD_APPEND] ? 6'd32 : 6'd24;
      end
      REG_GPO:    rd_word = {gpo_q[7:4], pins_s, 24'h00_0000};  // [RULE_15]
      default:    rd_word = '0;
    endcase
  end

  // Command byte, then write byte or read shift
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      st_q   <= S_CMD;
      bcnt_q <= '0;
      len_q  <= 6'd8;
      addr_q <= '0;
      sh_q   <= '0;
    end else if (CE_I) begin
      if (cs_n_s) begin
        st_q   <= S_CMD;
        bcnt_q <= '0;
      end else if (rise) begin
        case (st_q)
          S_CMD: begin
            sh_q   <= {sh_q[30:0], din_s};
            bcnt_q <= bcnt_q + 6'd1;
            if (bcnt_q == 6'd7) begin
              bcnt_q <= '0;
              addr_q <= comm[2:0];
              if (comm[CMD_READ_BIT]) begin
                st_q  <= S_RD;
                sh_q  <= rd_word;
                len_q <= rd_len;
              end else begin
                st_q <= S_WR;
              end
            end
          end
          S_WR: begin
            sh_q   <= {sh_q[30:0], din_s};
            bcnt_q <= bcnt_q + 6'd1;
            if (bcnt_q == 6'd7) begin
              st_q   <= S_CMD;
              bcnt_q <= '0;
            end
          end
          S_RD: begin
            sh_q   <= {sh_q[30:0], 1'b0};
            bcnt_q <= bcnt_q + 6'd1;
            if (bcnt_q == len_q - 6'd1) begin
              st_q   <= S_CMD;
              bcnt_q <= '0;
            end
          end
          default: st_q <= S_CMD;
        endcase
      end
    end
  end

  // Data line shows the read bit, or ready while idle in a frame
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      dout_q <= 1'b1;
      oe_q   <= 1'b0;
    end else if (CE_I) begin
      dout_q <= (st_q == S_RD) ? sh_q[31] : rdy_n_q;
      oe_q   <= ~cs_n_s;
    end
  end

  assign LINK.dout_val = dout_q;
  assign LINK.dout_oe  = oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers; synchronisation never touches them
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      mode_q <= MODE_RST;  // [RULE_02]
      cfg_q  <= CONFIG_RST;
      gpo_q  <= GPO_RST;
    end else if (CE_I && wr_stb) begin
      case (addr_q)
        REG_MODE:   mode_q <= comm;
        REG_CONFIG: cfg_q  <= comm;
        REG_GPO:    gpo_q  <= comm;
        default:    mode_q <= mode_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General outputs, enabled in pairs
  assign GPO_PIN_O = gpo_q[3:0];  // [RULE_14]

  for (genvar i = 0; i < 4; i++) begin : g_pin_en
    assign GPO_PIN_OE_O[i] = gpo_q[(i < 2) ? GP_LO_EN : GP_HI_EN];  // [RULE_13]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input selection and coding
  assign TEMP_SEL_O = cfg_q[CF_TEMP_SEL];
  assign temp_code  = 24'(TEMP_KELVIN_I * TEMP_CODE_PER_K);
  always_comb begin
    if (cfg_q[CF_TEMP_SEL]) begin  // [RULE_11]
      sample = cfg_q[CF_BIPOLAR] ? MIDSCALE + temp_code : temp_code;  // [RULE_12]
    end else begin
      sample = ANALOG_CODE_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Filter and modulator timing
  // The extra cycle after sync rises stands in for the next master clock edge
  assign filt_rst = rst_all | ~sync_n_s | ~sync_prev_q;  // [RULE_06] [RULE_07]

  // Slow filter settling applies only to single conversions started by sync
  assign need_per = (mode_q[MD_START] & ~mode_q[MD_SINC3] & ~mode_q[MD_ZERO_LAT] & ~mode_q[MD_CHOP])
                    ? 3'(SETTLE_SLOW) : 3'd1;  // [RULE_10]
  assign upd = CE_I & ~filt_rst & run_q & (pcnt_q == 32'(OUT_PERIOD - 1)) & (nper_q == need_per - 3'd1);

  // Period and settle counters
  always_ff @(posedge CLK_SYS_I) begin
    if (filt_rst) begin
      pcnt_q <= '0;
      nper_q <= '0;
      run_q  <= 1'b1;
    end else if (CE_I && run_q) begin
      pcnt_q <= pcnt_q + 32'd1;
      if (pcnt_q == 32'(OUT_PERIOD - 1)) begin
        pcnt_q <= '0;
        nper_q <= nper_q + 3'd1;
        if (upd) begin
          nper_q <= '0;
          run_q  <= ~mode_q[MD_START];  // [RULE_09]
        end
      end
    end
  end

  // Result register
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      data_q <= '0;
    end else if (upd) begin
      data_q <= sample;
    end
  end

  // Ready: a new result beats a data read ending in the same cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (filt_rst) begin
      rdy_n_q <= 1'b1;
    end else if (CE_I) begin
      if (upd) begin
        rdy_n_q <= 1'b0;  // [RULE_09]
      end else if (rd_data_done) begin
        rdy_n_q <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### verilog/ars_pkg.sv
// Shared constants and types for the converter housekeeping link and its host controller
//
// Overview of operation
// [RULE_01] Forty consecutive ones on data input reset device
// [RULE_02] Serial reset clears logic, filter and registers
// [RULE_03] Same reset applied automatically at power-up
// [RULE_04] Host waits 500 us after reset before access
// [RULE_05] Host holds sync low four master cycles minimum
// [RULE_06] Sync low resets filter, keeps configuration
// [RULE_07] Filter released on clock after sync rises
// [RULE_08] Host raises sync on a master clock edge
// [RULE_09] Start mode: sync rise converts, ready then falls
// [RULE_10] Slow filter start mode takes four output periods
// [RULE_11] Temperature select bit routes sensor to converter
// [RULE_12] Bipolar temperature: midscale at zero, 2815 per degree
// [RULE_13] Output pins enabled in pairs by two bits
// [RULE_14] Enabled pin drives its own level bit
// [RULE_15] Output register read returns sensed pin levels
// [RULE_16] Host pulses sync after switching output pins
// [RULE_17] Parity enable bit activates parity generation
// [RULE_18] Parity needs status appended after 24-bit result
// [RULE_19] Status parity bit makes ones count even
// [RULE_20] Host flags odd ones count as corruption
// [RULE_21] Zero bit clears the consecutive-ones counter
`default_nettype none

package ars_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ          = 200;
  localparam int RESET_ONES       = 40;
  localparam int RESET_WAIT_US    = 500;
  localparam int RESET_WAIT_CYC   = RESET_WAIT_US * CLK_MHZ;
  localparam int SYNC_LOW_MCLK    = 4;
  // Two extra cycles cover the synchroniser skew at the device
  localparam int SYNC_LOW_CYC     = SYNC_LOW_MCLK + 2;
  localparam int SCLK_HALF_CYC    = 8;
  localparam int OUT_PERIOD_CYC   = 256;
  localparam int SETTLE_SLOW      = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Device register map (3-bit address in the command byte)
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_MODE   = 3'h1;
  localparam logic [2:0] REG_CONFIG = 3'h2;
  localparam logic [2:0] REG_DATA   = 3'h3;
  localparam logic [2:0] REG_GPO    = 3'h5;
  localparam int CMD_READ_BIT       = 7;

  // Status fields
  localparam int ST_RDY_BIT = 7;
  localparam int ST_PAR_BIT = 4;

  // Mode fields
  localparam int MD_PAR_EN   = 0;
  localparam int MD_APPEND   = 1;
  localparam int MD_START    = 2;
  localparam int MD_SINC3    = 3;
  localparam int MD_ZERO_LAT = 4;
  localparam int MD_CHOP     = 5;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Configuration fields
  localparam int CF_TEMP_SEL = 0;
  localparam int CF_BIPOLAR  = 3;
  localparam logic [7:0] CONFIG_RST = 8'h08;

  // General output control fields
  localparam int GP_LO_EN = 4;
  localparam int GP_HI_EN = 5;
  localparam logic [7:0] GPO_RST = 8'h00;

  // Conversion coding
  localparam logic [23:0] MIDSCALE      = 24'h80_0000;
  localparam int          TEMP_CODE_PER_K = 2815;

  ////////////////////////////////////////////////////////////////////////////////
  // Host register map (APB byte addresses)
  localparam logic [7:0] H_CMD    = 8'h00;
  localparam logic [7:0] H_WDATA  = 8'h04;
  localparam logic [7:0] H_RDATA  = 8'h08;
  localparam logic [7:0] H_STATUS = 8'h0C;
  localparam int HC_READ  = 8;
  localparam int HC_LONG  = 9;
  localparam int HC_RESET = 10;
  localparam int HC_SYNC  = 11;
  localparam int HS_BUSY  = 0;
  localparam int HS_PERR  = 1;
  localparam int HS_RDY   = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // State machines
  typedef enum logic [2:0] {
    S_CMD = 3'b001,
    S_WR  = 3'b010,
    S_RD  = 3'b100
  } ars_ser_e;

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_FRAME = 4'b0010,
    H_WAIT  = 4'b0100,
    H_SYNC  = 4'b1000
  } ars_host_e;

endpackage

`default_nettype wire

// ### verilog/ars_link_if.sv
// Serial link between the host controller and the converter housekeeping logic
`default_nettype none

interface ars_link_if;
  logic sclk;      // Serial clock, idles high, made by the host
  logic cs_n;      // Frame select, active low
  logic din;       // Host to device data
  logic dout_val;  // Device data value
  logic dout_oe;   // Device drives data line
  logic dout;      // Resolved data line, pulled high when undriven
  logic sync_n;    // Synchronisation, active low

  // Pull-up on the shared data line
  assign dout = dout_oe ? dout_val : 1'b1;

  modport dev  (input sclk, cs_n, din, sync_n, output dout_val, dout_oe);
  modport host (output sclk, cs_n, din, sync_n, input dout);
endinterface

`default_nettype wire

// ### verilog/ars_host.sv
// Host controller: APB registers driving the serial link of the converter
`default_nettype none

module ars_host
  import ars_pkg::*;
#(
  parameter int RESET_WAIT = RESET_WAIT_CYC,  // Cycles of silence after serial reset
  parameter int HALF       = SCLK_HALF_CYC    // Cycles per serial clock half period
) (
  input  wire logic        CLK_SYS_I,  // Core clock
  input  wire logic        NRST_I,     // Reset, active low
  input  wire logic        CE_I,       // Clock enable
  input  wire logic        PSEL_I,     // APB select
  input  wire logic        PENABLE_I,  // APB enable
  input  wire logic        PWRITE_I,   // APB write
  input  wire logic [7:0]  PADDR_I,    // APB address
  input  wire logic [31:0] PWDATA_I,   // APB write data
  output logic      [31:0] PRDATA_O,   // APB read data
  output logic             PREADY_O,   // APB ready
  output logic             PSLVERR_O,  // APB error
  ars_link_if.host         LINK,       // Serial link
  output logic             BUSY_O      // Operation in progress
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  ars_host_e   hst_q;
  logic [31:0] tmr_q;
  logic [5:0]  nbit_q;
  logic [39:0] tx_q;
  logic [31:0] rx_q;
  logic [31:0] rdata_q;
  logic [7:0]  wdata_q;
  logic        long_q;
  logic        rst_op_q;
  logic        sync_after_q;
  logic        perr_q;
  logic        sclk_q;
  logic        cs_n_q;
  logic        din_q;
  logic        sync_n_q;
  logic        d1_q;
  logic        d2_q;
  logic [31:0] prdata_q;
  logic        apb_wr;
  logic        start;
  logic [7:0]  comm;
  logic [5:0]  dlen;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave; a stalled clock enable also stalls the bus
  assign PREADY_O  = CE_I;
  assign PSLVERR_O = 1'b0;
  assign apb_wr    = CE_I & PSEL_I & PENABLE_I & PWRITE_I;
  assign start     = apb_wr & (PADDR_I == H_CMD) & (hst_q == H_IDLE);
  assign BUSY_O    = (hst_q != H_IDLE);
  assign PRDATA_O  = prdata_q;

  // Read data captured in the setup cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      prdata_q <= '0;
    end else if (CE_I && PSEL_I && !PENABLE_I) begin
      case (PADDR_I)
        H_WDATA:  prdata_q <= {24'h00_0000, wdata_q};
        H_RDATA:  prdata_q <= rdata_q;
        H_STATUS: prdata_q <= {29'h0, ~d2_q, perr_q, BUSY_O};
        default:  prdata_q <= '0;
      endcase
    end
  end

  // Write data holding register
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      wdata_q <= '0;
    end else if (apb_wr && PADDR_I == H_WDATA) begin
      wdata_q <= PWDATA_I[7:0];
    end
  end

  // Returned data line synchroniser
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      d1_q <= 1'b1;
      d2_q <= 1'b1;
    end else if (CE_I) begin
      d1_q <= LINK.dout;
      d2_q <= d1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  assign comm = {PWDATA_I[HC_READ], 4'h0, PWDATA_I[2:0]};
  assign dlen = !PWDATA_I[HC_READ] ? 6'd8 :
                (PWDATA_I[2:0] != REG_DATA) ? 6'd8 :
                PWDATA_I[HC_LONG] ? 6'd32 : 6'd24;

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      hst_q        <= H_IDLE;
      tmr_q        <= '0;
      nbit_q       <= '0;
      tx_q         <= '0;
      rx_q         <= '0;
      rdata_q      <= '0;
      long_q       <= 1'b0;
      rst_op_q     <= 1'b0;
      sync_after_q <= 1'b0;
      perr_q       <= 1'b0;
      sclk_q       <= 1'b1;
      cs_n_q       <= 1'b1;
      din_q        <= 1'b0;
      sync_n_q     <= 1'b1;
    end else if (CE_I) begin
      case (hst_q)
        H_IDLE: begin
          if (start) begin
            perr_q <= 1'b0;
            tmr_q  <= '0;
            if (PWDATA_I[HC_RESET]) begin
              tx_q     <= '1;  // [RULE_01]
              nbit_q   <= 6'(RESET_ONES);
              rst_op_q <= 1'b1;
              long_q   <= 1'b0;  // No parity verdict on a reset frame
              cs_n_q   <= 1'b0;
              hst_q    <= H_FRAME;
            end else if (PWDATA_I[HC_SYNC]) begin
              sync_n_q <= 1'b0;  // [RULE_05]
              tmr_q    <= 32'(SYNC_LOW_CYC - 1);
              hst_q    <= H_SYNC;
            end else begin
              tx_q         <= {comm, wdata_q, 24'h00_0000};
              nbit_q       <= 6'd8 + dlen;
              long_q       <= PWDATA_I[HC_READ] & (dlen == 6'd32);  // [RULE_18]
              sync_after_q <= ~PWDATA_I[HC_READ] & (PWDATA_I[2:0] == REG_GPO);  // [RULE_16]
              cs_n_q       <= 1'b0;
              hst_q        <= H_FRAME;
            end
          end
        end
        H_FRAME: begin
          if (tmr_q != 32'd0) begin
            tmr_q <= tmr_q - 32'd1;
          end else if (sclk_q) begin
            if (nbit_q == 6'd0) begin
              cs_n_q  <= 1'b1;
              rdata_q <= rx_q;
              // Odd ones over result and parity bit mark a corrupt read
              perr_q  <= long_q & ^{rx_q[31:8], rx_q[ST_PAR_BIT]};  // [RULE_20]
              tmr_q   <= rst_op_q ? 32'(RESET_WAIT - 1) : 32'(HALF - 1);  // [RULE_04]
              hst_q   <= H_WAIT;
            end else begin
              sclk_q <= 1'b0;
              din_q  <= tx_q[39];
              tx_q   <= {tx_q[38:0], 1'b1};
              tmr_q  <= 32'(HALF - 1);
            end
          end else begin
            rx_q   <= {rx_q[30:0], d2_q};
            sclk_q <= 1'b1;
            nbit_q <= nbit_q - 6'd1;
            tmr_q  <= 32'(HALF - 1);
          end
        end
        H_WAIT: begin
          rst_op_q <= 1'b0;
          din_q    <= 1'b0;
          if (tmr_q != 32'd0) begin
            tmr_q <= tmr_q - 32'd1;
          end else if (sync_after_q) begin
            sync_after_q <= 1'b0;
            sync_n_q     <= 1'b0;
            tmr_q        <= 32'(SYNC_LOW_CYC - 1);
            hst_q        <= H_SYNC;
          end else begin
            hst_q <= H_IDLE;
          end
        end
        H_SYNC: begin
          if (tmr_q != 32'd0) begin
            tmr_q <= tmr_q - 32'd1;
          end else begin
            sync_n_q <= 1'b1;  // [RULE_08]
            tmr_q    <= 32'(HALF - 1);
            hst_q    <= H_WAIT;
          end
        end
        default: hst_q <= H_IDLE;
      endcase
    end
  end

  // Link outputs straight from flops, changed only on core rising edges
  assign LINK.sclk   = sclk_q;
  assign LINK.cs_n   = cs_n_q;
  assign LINK.din    = din_q;
  assign LINK.sync_n = sync_n_q;

endmodule

`default_nettype wire

// ### verif/ars_link_asserts.sv
// Protocol assertions on the serial link between host controller and device
`default_nettype none

module ars_link_asserts (
  input wire logic CLK_SYS_I, // Core clock
  input wire logic NRST_I,    // Reset, active low
  input wire logic sclk,      // Serial clock
  input wire logic cs_n,      // Frame select
  input wire logic din,       // Host data
  input wire logic dout_oe,   // Device drives data
  input wire logic sync_n     // Synchronisation
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] ones_q;

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  ////////////////////////////////////////////////////////////////////////////////
  // Run of ones taken on the clock; saturates so a long run never wraps to zero
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      ones_q <= 6'd0;
    end else if ($rose(sclk) && !cs_n) begin
      ones_q <= din ? ones_q + {5'd0, ones_q != 6'd63} : 6'd0;
    end
  end

  // Link at rest between frames
  sequence s_gap;
    cs_n && sclk;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_cs_then_clock: assert property ($fell(cs_n) |=> $fell(sclk))
    else $error("clock did not follow frame select");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase short");
  a_high_half: assert property ($rose(sclk) && !cs_n |-> sclk [*8])
    else $error("serial clock high phase short");
  a_din_steady: assert property ($rose(sclk) && !cs_n |=> $stable(din) [*7])
    else $error("data moved while clock high");
  a_sync_width: assert property ($fell(sync_n) |-> !sync_n [*4])
    else $error("sync pulse too short");
  a_sync_gap: assert property (!sync_n |-> s_gap)
    else $error("sync low inside a frame");
  a_oe_release: assert property ($rose(cs_n) |-> ##[0:6] !dout_oe)
    else $error("data line held after frame");
  a_reset_quiet: assert property ($rose(cs_n) && ones_q >= 6'd40 |-> s_gap [*8])
    else $error("link busy right after serial reset");
endmodule

`default_nettype wire

// ### verif/test_adc_reset_sync_gpo_parity.sv
// Bench: host controller and converter logic joined over the serial link
`default_nettype none

module test_adc_reset_sync_gpo_parity;
  timeunit 1ns;
  timeprecision 1ps;
  import ars_pkg::*;
  logic        clk, nrst, psel, pen, pwr, prdy, perr, busy, tsel;
  logic        ce = 1'b1;
  logic [7:0]  paddr;
  logic [31:0] pwd, prd, rd;
  logic [23:0] code;
  logic [11:0] kel;
  logic [3:0]  pin_o, pin_oe, sh, lev, oe;
  logic [3:0]  pin_i = 4'h0;
  int          n_fail, n_checks, cyc;

  ars_link_if link ();
  ars_host #(.RESET_WAIT(50)) ars_host_i (.CLK_SYS_I(clk), .NRST_I(nrst), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
    .PSLVERR_O(perr), .LINK(link.host), .BUSY_O(busy));
  ars_dev #(.OUT_PERIOD(32)) ars_dev_i (.CLK_SYS_I(clk), .NRST_I(nrst), .CE_I(ce), .LINK(link.dev),
    .ANALOG_CODE_I(code), .TEMP_KELVIN_I(kel), .GPO_PIN_I(pin_i), .GPO_PIN_O(pin_o),
    .GPO_PIN_OE_O(pin_oe), .TEMP_SEL_O(tsel));
  ars_link_asserts ars_link_asserts_i (.CLK_SYS_I(clk), .NRST_I(nrst), .sclk(link.sclk),
    .cs_n(link.cs_n), .din(link.din), .dout_oe(link.dout_oe), .sync_n(link.sync_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Undriven pins wander; bits set in sh fake a shorted driven pin
  always @(posedge clk) pin_i <= (pin_oe & (pin_o ^ sh)) | (~pin_oe & ~pin_i);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] temp_exp(input logic bip, input logic [11:0] k);
    return (bip ? MIDSCALE : 24'h00_0000) + 24'(TEMP_CODE_PER_K * k);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; read data lands in rd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Command then poll busy, so no request lands while a frame runs
  task automatic cmd(input logic [31:0] v);
    apb(1'b1, H_CMD, v);
    do begin
      apb(1'b0, H_STATUS, 32'h0000_0000);
    end while (rd[HS_BUSY] !== 1'b0);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    apb(1'b1, H_WDATA, 32'(d));
    cmd(32'(a));
  endtask

  task automatic rdv(input logic [2:0] a, input logic l);
    cmd({22'h0, l, 1'b1, 5'h0, a});
    apb(1'b0, H_RDATA, 32'h0000_0000);
  endtask

  task automatic conv(input logic l);
    do begin
      rdv(REG_STATUS, 1'b0);
    end while (rd[ST_RDY_BIT] !== 1'b0);
    rdv(REG_DATA, l);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hb72737ca));
    {nrst, psel, pen, pwr, paddr, pwd, code, kel, sh} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", {rd[31:1], perr}, 32'h0000_0000);
    rdv(REG_CONFIG, 1'b0);
    chk("config", rd[7:0], CONFIG_RST);
    for (int i = 0; i < 4; i++) begin
      lev = 4'($urandom);
      sh <= 4'($urandom);
      oe = {{2{i[1]}}, {2{i[0]}}};
      wr(REG_GPO, {2'b00, i[1:0], lev});
      chk("oe", pin_oe, oe);
      chk("pin", pin_o & oe, lev & oe);
      rdv(REG_GPO, 1'b0);
      chk("sense", rd[5:0] & {2'b11, oe}, {i[1:0], (lev ^ sh) & oe});
    end
    for (int i = 0; i < 4; i++) begin
      kel <= i[0] ? 12'($urandom_range(2900)) : 12'h000;
      wr(REG_CONFIG, {4'h0, i[1], 3'b001});
      chk("tsel", tsel, 1'b1);
      conv(1'b0);
      conv(1'b0);
      chk("temp", rd[23:0], temp_exp(i[1], kel));
    end
    wr(REG_CONFIG, CONFIG_RST);
    wr(REG_MODE, 8'h03);
    for (int i = 0; i < 4; i++) begin
      code <= i == 0 ? 24'h00_0000 : i == 1 ? 24'hFF_FFFF : 24'($urandom);
      conv(1'b1);
      chk("result", rd[31:8], code);
      chk("parity", rd[ST_PAR_BIT], ^code);
      apb(1'b0, H_STATUS, 32'h0000_0000);
      chk("perr", rd[HS_PERR], 1'b0);
    end
    wr(REG_MODE, 8'h04);
    cmd(32'h0000_0800);
    conv(1'b0);
    repeat (4 * 32) @(posedge clk);
    rdv(REG_STATUS, 1'b0);
    chk("held", rd[ST_RDY_BIT], 1'b1);
    cmd(32'h0000_0800);
    // A frame shows ready on the line; three periods after sync is too soon, four are not
    apb(1'b1, H_CMD, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      repeat (90) @(posedge clk);
      apb(1'b0, H_STATUS, 32'h0000_0000);
      chk("started", rd[HS_RDY], i[0]);
    end
    repeat (100) @(posedge clk);
    rdv(REG_MODE, 1'b0);
    chk("kept", rd[7:0], 8'h04);
    wr(REG_CONFIG, 8'h09);
    cmd(32'h0000_0400);
    chk("tsel", tsel, 1'b0);
    chk("oe", pin_oe, 4'h0);
    rdv(REG_MODE, 1'b0);
    chk("mode", rd[7:0], MODE_RST);
    complete_run();
  end
endmodule

`default_nettype wire
